// ### hw/nvmpr_pkg.sv
package nvmpr_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 22;
  localparam int DATA_W      = 16;
  localparam int PA_W        = 17;
  localparam int TBL_DATA_W  = 8;
  localparam int USER_BLOCKS = 4;
  localparam int SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CP_CFG_ADDR   = 22'h300008;
  localparam logic [ADDR_W-1:0] TRG_CFG_ADDR  = 22'h30000a;
  localparam logic [ADDR_W-1:0] BLK_STAT_ADDR = 22'h300100;
  localparam logic [ADDR_W-1:0] BLK_DST_ADDR  = 22'h300102;
  localparam logic [ADDR_W-1:0] BLK_CNT_ADDR  = 22'h300104;
  localparam logic [ADDR_W-1:0] REV_ADDR      = 22'h3ffffc;
  localparam logic [ADDR_W-1:0] ID_ADDR       = 22'h3ffffe;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int DPROT_BIT      = 1;
  localparam int PPROT_BIT      = 0;
  localparam int BOOT_GUARD_BIT = 9;
  localparam int USER_GUARD_LSB = 0;
  localparam int FAMILY_LSB     = 12;
  localparam int MAJOR_LSB      = 6;
  localparam int MINOR_LSB      = 0;
  localparam int FAMILY_W       = 4;
  localparam int MAJOR_W        = 6;
  localparam int MINOR_W        = 6;
  localparam int BLK_STAT_BIT   = 0;

  localparam logic [FAMILY_W-1:0] FAMILY_PATTERN = 4'h6;   // arbitrary family pattern
  localparam logic [1:0]          CP_CFG_RST     = 2'h3;
  localparam logic [DATA_W-1:0]   TRG_CFG_RST    = 16'h020f;
  localparam logic [DATA_W-1:0]   TRG_CFG_WMASK  = 16'h020f;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    NVMPR_RGN_USER0 = 3'b000,
    NVMPR_RGN_USER1 = 3'b001,
    NVMPR_RGN_USER2 = 3'b010,
    NVMPR_RGN_USER3 = 3'b011,
    NVMPR_RGN_BOOT  = 3'b100,
    NVMPR_RGN_OPEN  = 3'b111
  } nvmpr_region_e;

  typedef struct packed {
    logic            vld;
    logic [PA_W-1:0] src_addr;
    logic [PA_W-1:0] dst_addr;
  } nvmpr_tbl_req_s;

  typedef struct packed {
    logic                  vld;
    logic                  blocked;
    logic [PA_W-1:0]       dst_addr;
    logic [TBL_DATA_W-1:0] data;
  } nvmpr_tbl_rsp_s;

endpackage : nvmpr_pkg

// ### hw/nvmpr_guard.sv
`timescale 1ns/100ps
module nvmpr_guard #(
  parameter logic [nvmpr_pkg::PA_W-1:0] BOOT_SIZE = 17'h00800,
  parameter int                         BLK_SHIFT = 14
) (
  input  wire logic                                   sys_clk_i,        // system clock
  input  wire logic                                   rst_i,            // async reset, high
  input  wire nvmpr_pkg::nvmpr_tbl_req_s              req_i,            // table read request
  input  wire logic [nvmpr_pkg::TBL_DATA_W-1:0]       mem_data_i,       // raw memory byte
  input  wire logic                                   boot_guard_n_i,   // boot block guard, 0 guards
  input  wire logic [nvmpr_pkg::USER_BLOCKS-1:0]      user_guard_n_i,   // user block guards, 0 guards
  output nvmpr_pkg::nvmpr_tbl_rsp_s                   rsp_o             // registered answer
);
  import nvmpr_pkg::*;

  // ---------------------------------------------------------------
  // region decode
  // ---------------------------------------------------------------
  function automatic nvmpr_region_e region_of(input logic [PA_W-1:0] a);
    logic [PA_W-1:0] blk;
    blk = a >> BLK_SHIFT;
    if (a < BOOT_SIZE) begin
      region_of = NVMPR_RGN_BOOT;
    end else if (blk < PA_W'(USER_BLOCKS)) begin
      region_of = nvmpr_region_e'({1'b0, blk[1:0]});
    end else begin
      region_of = NVMPR_RGN_OPEN;
    end
  endfunction : region_of

  nvmpr_region_e  src_rgn;
  nvmpr_region_e  dst_rgn;
  logic           dst_open_n;
  logic           rd_blocked;
  nvmpr_tbl_rsp_s rsp_next;

  assign src_rgn = region_of(req_i.src_addr);
  assign dst_rgn = region_of(req_i.dst_addr);
  // reads from inside the block itself are never guarded
  assign dst_open_n = (dst_rgn == NVMPR_RGN_BOOT) ? boot_guard_n_i :
                      (dst_rgn == NVMPR_RGN_OPEN) ? 1'b1 :
                      user_guard_n_i[dst_rgn[1:0]];
  assign rd_blocked = req_i.vld && (src_rgn != dst_rgn) && !dst_open_n;

  assign rsp_next.vld      = req_i.vld;
  assign rsp_next.blocked  = rd_blocked;
  assign rsp_next.dst_addr = req_i.dst_addr;
  assign rsp_next.data     = rd_blocked ? '0 : mem_data_i;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o <= rsp_next;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_boot_guard_block: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i.vld && dst_rgn == NVMPR_RGN_BOOT && src_rgn != NVMPR_RGN_BOOT
    |=> rsp_o.blocked == !$past(boot_guard_n_i))
    else $error("boot block guard not applied");

  chk_user_guard_block: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i.vld && !dst_rgn[2] && src_rgn != dst_rgn
    |=> rsp_o.blocked == !$past(user_guard_n_i[dst_rgn[1:0]]))
    else $error("user block guard not applied");

  chk_blocked_zero_data: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i.vld ##1 rsp_o.blocked |-> rsp_o.data == '0 && rsp_o.vld)
    else $error("blocked read leaked data");

endmodule : nvmpr_guard

// ### hw/nvmpr_top.sv
// Notes on behaviour
// - data memory protected while its flag is 0
// - program memory protected while its flag is 0
// - boot guard 0 blocks foreign table reads
// - user block guard 0 blocks foreign reads
// - guard flags at bit 9 and 3:0
// - identity word read only at top address
// - revision bits 15:12 fixed family pattern
// - revision bits 11:6 hold major revision
// - revision bits 5:0 hold minor revision
// - protect flags bits 1,0, read only, reset 1
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module nvmpr_top #(
  parameter logic [nvmpr_pkg::DATA_W-1:0]  PART_ID   = 16'h5a3c,    // arbitrary identity value
  parameter logic [nvmpr_pkg::MAJOR_W-1:0] MAJOR_REV = 6'h03,    // arbitrary revision value
  parameter logic [nvmpr_pkg::MINOR_W-1:0] MINOR_REV = 6'h01,
  parameter logic [nvmpr_pkg::PA_W-1:0]    BOOT_SIZE = 17'h00800,
  parameter int                            BLK_SHIFT = 14
) (
  input  wire logic                                 sys_clk_i,          // system clock
  input  wire logic                                 rst_i,              // async reset, high
  input  wire logic [nvmpr_pkg::ADDR_W-1:0]         reg_addr_i,         // register address
  input  wire logic [nvmpr_pkg::DATA_W-1:0]         reg_wdata_i,        // register write data
  input  wire logic                                 reg_wr_i,           // write strobe
  input  wire logic                                 reg_rd_i,           // read strobe
  output logic      [nvmpr_pkg::DATA_W-1:0]         reg_rdata_o,        // read data, next cycle
  input  wire logic [1:0]                           cp_strap_i,         // stored protect flags
  input  wire nvmpr_pkg::nvmpr_tbl_req_s            tbl_req_i,          // table read request
  input  wire logic [nvmpr_pkg::TBL_DATA_W-1:0]     tbl_mem_data_i,     // memory byte for request
  output nvmpr_pkg::nvmpr_tbl_rsp_s                 tbl_rsp_o,          // table read answer
  output logic                                      data_mem_protect_o, // data memory protected
  output logic                                      prog_mem_protect_o  // program memory protected
);
  import nvmpr_pkg::*;

  default clocking chk_cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0]        cp_sync1_reg;
  logic [1:0]        cp_sync2_reg;
  logic [1:0]        code_protect_config_reg;
  logic              data_prot_reg;
  logic              prog_prot_reg;
  logic [DATA_W-1:0] table_read_guard_config_reg;
  logic [DATA_W-1:0] table_read_guard_config_next;
  logic              blk_stat_reg;
  logic              blk_stat_next;
  logic [PA_W-1:0]   blk_dst_reg;
  logic [PA_W-1:0]   blk_dst_next;
  logic [DATA_W-1:0] blk_cnt_reg;
  logic [DATA_W-1:0] blk_cnt_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire sel_cp   = (reg_addr_i == CP_CFG_ADDR);
  wire sel_trg  = (reg_addr_i == TRG_CFG_ADDR);
  wire sel_stat = (reg_addr_i == BLK_STAT_ADDR);
  wire sel_dst  = (reg_addr_i == BLK_DST_ADDR);
  wire sel_cnt  = (reg_addr_i == BLK_CNT_ADDR);
  wire sel_rev  = (reg_addr_i == REV_ADDR);
  wire sel_id   = (reg_addr_i == ID_ADDR);

  wire wr_trg  = reg_wr_i && sel_trg;
  wire wr_stat = reg_wr_i && sel_stat;
  wire wr_cnt  = reg_wr_i && sel_cnt;

  // ---------------------------------------------------------------
  // fixed identification words
  // ---------------------------------------------------------------
  wire [DATA_W-1:0] rev_word = {FAMILY_PATTERN, MAJOR_REV, MINOR_REV};
  wire [DATA_W-1:0] id_word  = PART_ID;

  // ---------------------------------------------------------------
  // guard flags
  // ---------------------------------------------------------------
  wire                   boot_block_read_guard_n = table_read_guard_config_reg[BOOT_GUARD_BIT];
  wire [USER_BLOCKS-1:0] user_block_read_guard_n =
    table_read_guard_config_reg[USER_GUARD_LSB +: USER_BLOCKS];

  // only the guard bits hold state; the rest read as zero
  assign table_read_guard_config_next = wr_trg ? (reg_wdata_i & TRG_CFG_WMASK)
                                               : table_read_guard_config_reg;

  // ---------------------------------------------------------------
  // table read path
  // ---------------------------------------------------------------
  nvmpr_guard #(
    .BOOT_SIZE (BOOT_SIZE),
    .BLK_SHIFT (BLK_SHIFT)
  ) u_guard (
    .sys_clk_i      (sys_clk_i),
    .rst_i          (rst_i),
    .req_i          (tbl_req_i),
    .mem_data_i     (tbl_mem_data_i),
    .boot_guard_n_i (boot_block_read_guard_n),
    .user_guard_n_i (user_block_read_guard_n),
    .rsp_o          (tbl_rsp_o)
  );

  // ---------------------------------------------------------------
  // blocked read record
  // ---------------------------------------------------------------
  wire blk_evt = tbl_rsp_o.vld && tbl_rsp_o.blocked;
  wire cnt_full = (blk_cnt_reg == {DATA_W{1'b1}});

  // a new blocked read in the clearing cycle keeps the flag set
  assign blk_stat_next = blk_evt || (blk_stat_reg && !(wr_stat && reg_wdata_i[BLK_STAT_BIT]));
  assign blk_dst_next  = blk_evt ? tbl_rsp_o.dst_addr : blk_dst_reg;
  // counter saturates so software never sees a wrap to zero
  assign blk_cnt_next  = (wr_cnt && blk_evt) ? DATA_W'(1) :
                         wr_cnt              ? '0 :
                         (blk_evt && !cnt_full) ? blk_cnt_reg + DATA_W'(1) :
                         blk_cnt_reg;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [DATA_W-1:0] cp_word   = {{(DATA_W-2){1'b0}}, code_protect_config_reg};
  wire [DATA_W-1:0] stat_word = {{(DATA_W-1){1'b0}}, blk_stat_reg};
  wire [DATA_W-1:0] dst_word  = blk_dst_reg[DATA_W-1:0];

  // unmapped addresses answer zero; data stands for one cycle only
  wire [DATA_W-1:0] rd_mux = sel_cp   ? cp_word :
                             sel_trg  ? table_read_guard_config_reg :
                             sel_stat ? stat_word :
                             sel_dst  ? dst_word :
                             sel_cnt  ? blk_cnt_reg :
                             sel_rev  ? rev_word :
                             sel_id   ? id_word :
                             '0;
  assign rdata_next = reg_rd_i ? rd_mux : '0;

  // ---------------------------------------------------------------
  // protect flag capture
  // ---------------------------------------------------------------
  // stored flags arrive from outside this clock, hence two stages
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cp_sync1_reg <= CP_CFG_RST;
      cp_sync2_reg <= CP_CFG_RST;
    end else begin
      cp_sync1_reg <= cp_strap_i;
      cp_sync2_reg <= cp_sync1_reg;
    end
  end

  // bus writes never reach these: read only from software
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_protect_config_reg <= CP_CFG_RST;
      data_prot_reg           <= 1'b0;
      prog_prot_reg           <= 1'b0;
    end else begin
      code_protect_config_reg <= cp_sync2_reg;
      data_prot_reg           <= !cp_sync2_reg[DPROT_BIT];
      prog_prot_reg           <= !cp_sync2_reg[PPROT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      table_read_guard_config_reg <= TRG_CFG_RST;
      rdata_reg                   <= '0;
    end else begin
      table_read_guard_config_reg <= table_read_guard_config_next;
      rdata_reg                   <= rdata_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blk_stat_reg <= 1'b0;
      blk_dst_reg  <= '0;
      blk_cnt_reg  <= '0;
    end else begin
      blk_stat_reg <= blk_stat_next;
      blk_dst_reg  <= blk_dst_next;
      blk_cnt_reg  <= blk_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o        = rdata_reg;
  assign data_mem_protect_o = data_prot_reg;
  assign prog_mem_protect_o = prog_prot_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_data_mem_protect: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ##1 data_mem_protect_o == !$past(cp_sync2_reg[DPROT_BIT]))
    else $error("data memory protect does not follow flag");

  chk_prog_mem_protect: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ##1 prog_mem_protect_o == !$past(cp_sync2_reg[PPROT_BIT]))
    else $error("program memory protect does not follow flag");

  chk_guard_cfg_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_trg |=> table_read_guard_config_reg == ($past(reg_wdata_i) & TRG_CFG_WMASK))
    else $error("guard config write not masked to guard bits");

  chk_identity_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && sel_id |=> reg_rdata_o == PART_ID)
    else $error("identity word read wrong");

  chk_rev_family_bits: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && sel_rev |=> reg_rdata_o[FAMILY_LSB +: FAMILY_W] == FAMILY_PATTERN)
    else $error("family pattern wrong");

  chk_rev_major_field: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && sel_rev |=> reg_rdata_o[MAJOR_LSB +: MAJOR_W] == MAJOR_REV)
    else $error("major revision field wrong");

  chk_rev_minor_field: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && sel_rev |=> reg_rdata_o[MINOR_LSB +: MINOR_W] == MINOR_REV)
    else $error("minor revision field wrong");

  chk_cp_cfg_readonly: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_wr_i && sel_cp |=> code_protect_config_reg == $past(cp_sync2_reg))
    else $error("protect flags changed by a write");

  chk_id_read_no_effect: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && (sel_id || sel_rev) |=> $stable(table_read_guard_config_reg) && $stable(blk_cnt_reg)
                                       || $past(blk_evt))
    else $error("identity read had a side effect");

  chk_stat_set_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    blk_evt |=> blk_stat_reg)
    else $error("blocked read flag lost");

  chk_rdata_one_cycle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !reg_rd_i |=> reg_rdata_o == '0)
    else $error("read data outside its cycle");

  chk_rd_cp_word: assert property (
    reg_rd_i && sel_cp |=> reg_rdata_o == DATA_W'($past(code_protect_config_reg)))
    else $error("protect flag read wrong");

  chk_rd_guard_word: assert property (
    reg_rd_i && sel_trg |=> reg_rdata_o == $past(table_read_guard_config_reg))
    else $error("guard config read wrong");

  chk_rd_stat_word: assert property (
    reg_rd_i && sel_stat |=> reg_rdata_o == DATA_W'($past(blk_stat_reg)))
    else $error("blocked flag read wrong");

  chk_rd_dst_word: assert property (
    reg_rd_i && sel_dst |=> reg_rdata_o == $past(blk_dst_reg[DATA_W-1:0]))
    else $error("blocked address read wrong");

  chk_rd_cnt_word: assert property (
    reg_rd_i && sel_cnt |=> reg_rdata_o == $past(blk_cnt_reg))
    else $error("blocked count read wrong");

  chk_rd_unmapped_zero: assert property (
    reg_rd_i && !(sel_cp || sel_trg || sel_stat || sel_dst || sel_cnt || sel_rev || sel_id) |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");

  chk_wr_no_rdata: assert property (
    reg_wr_i |=> reg_rdata_o == '0)
    else $error("write produced read data");

  chk_guard_cfg_hold: assert property (
    !wr_trg |=> $stable(table_read_guard_config_reg))
    else $error("guard config changed without write");

  chk_guard_cfg_spare: assert property (
    (table_read_guard_config_reg & ~TRG_CFG_WMASK) == '0)
    else $error("guard config spare bits set");

  chk_guard_wr_boot: assert property (
    wr_trg |=> boot_block_read_guard_n == $past(reg_wdata_i[BOOT_GUARD_BIT]))
    else $error("boot guard not at bit 9");

  chk_guard_wr_user: assert property (
    wr_trg |=> user_block_read_guard_n == $past(reg_wdata_i[USER_GUARD_LSB +: USER_BLOCKS]))
    else $error("user guards not at low bits");

  chk_data_prot_pair: assert property (
    data_mem_protect_o == !code_protect_config_reg[DPROT_BIT])
    else $error("data protect disagrees with flag");

  chk_prog_prot_pair: assert property (
    prog_mem_protect_o == !code_protect_config_reg[PPROT_BIT])
    else $error("program protect disagrees with flag");

  chk_sync_chain: assert property (
    ##1 cp_sync2_reg == $past(cp_sync1_reg))
    else $error("flag synchroniser skipped a stage");

  chk_stat_clear: assert property (
    wr_stat && reg_wdata_i[BLK_STAT_BIT] && !blk_evt |=> !blk_stat_reg)
    else $error("blocked flag not cleared");

  chk_stat_hold: assert property (
    !blk_evt && !wr_stat |=> blk_stat_reg == $past(blk_stat_reg))
    else $error("blocked flag changed by itself");

  chk_dst_capture: assert property (
    blk_evt |=> blk_dst_reg == $past(tbl_rsp_o.dst_addr))
    else $error("blocked address not captured");

  chk_dst_hold: assert property (
    !blk_evt |=> $stable(blk_dst_reg))
    else $error("blocked address changed by itself");

  chk_cnt_step: assert property (
    blk_evt && !wr_cnt && !cnt_full |=> blk_cnt_reg == $past(blk_cnt_reg) + DATA_W'(1))
    else $error("blocked count did not step");

  chk_cnt_clear: assert property (
    wr_cnt && !blk_evt |=> blk_cnt_reg == '0)
    else $error("blocked count not cleared");

  chk_cnt_hold: assert property (
    !blk_evt && !wr_cnt |=> $stable(blk_cnt_reg))
    else $error("blocked count changed by itself");

  chk_cnt_nonzero: assert property (
    blk_evt |=> blk_cnt_reg != '0)
    else $error("blocked read not counted");

  chk_rsp_follows_req: assert property (
    tbl_req_i.vld |=> tbl_rsp_o.vld)
    else $error("table read not answered");

  chk_rsp_idle: assert property (
    !tbl_req_i.vld |=> !tbl_rsp_o.vld)
    else $error("answer without request");

  chk_rsp_blocked_vld: assert property (
    tbl_rsp_o.blocked |-> tbl_rsp_o.vld)
    else $error("blocked flag without answer");

  chk_rsp_dst_echo: assert property (
    tbl_req_i.vld |=> tbl_rsp_o.dst_addr == $past(tbl_req_i.dst_addr))
    else $error("answer address wrong");

  chk_open_data_pass: assert property (
    tbl_req_i.vld ##1 !tbl_rsp_o.blocked |-> tbl_rsp_o.data == $past(tbl_mem_data_i))
    else $error("allowed read lost its data");

endmodule : nvmpr_top

// ### test/nvmpr_tb.sv
`timescale 1ns/100ps
module tb;
  import nvmpr_pkg::*;

  // ---------------------------------------------------------------
  // parameters and signals
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0]  TB_PART_ID = 16'hc3a5; // arbitrary identity value
  localparam logic [MAJOR_W-1:0] TB_MAJOR   = 6'h05;
  localparam logic [MINOR_W-1:0] TB_MINOR   = 6'h2a;
  localparam logic [PA_W-1:0]    FOREIGN    = 17'h10100; // unguarded span above block 3

  logic                  sys_clk   = 1'b0;
  logic                  rst       = 1'b1;
  logic [ADDR_W-1:0]     reg_addr  = '0;
  logic [DATA_W-1:0]     reg_wdata = '0;
  logic                  reg_wr    = 1'b0;
  logic                  reg_rd    = 1'b0;
  logic [DATA_W-1:0]     reg_rdata;
  logic [1:0]            cp_strap  = 2'h3;
  nvmpr_tbl_req_s        req       = '0;
  logic [TBL_DATA_W-1:0] mem_data  = '0;
  nvmpr_tbl_rsp_s        rsp;
  logic                  data_prot;
  logic                  prog_prot;
  int                    fails       = 0;
  int                    check_count = 0;

  always #2 sys_clk = ~sys_clk;

  nvmpr_top #(.PART_ID(TB_PART_ID), .MAJOR_REV(TB_MAJOR), .MINOR_REV(TB_MINOR)) nvmpr_top_inst (
    .sys_clk_i          (sys_clk),
    .rst_i              (rst),
    .reg_addr_i         (reg_addr),
    .reg_wdata_i        (reg_wdata),
    .reg_wr_i           (reg_wr),
    .reg_rd_i           (reg_rd),
    .reg_rdata_o        (reg_rdata),
    .cp_strap_i         (cp_strap),
    .tbl_req_i          (req),
    .tbl_mem_data_i     (mem_data),
    .tbl_rsp_o          (rsp),
    .data_mem_protect_o (data_prot),
    .prog_mem_protect_o (prog_prot)
  );

  // ---------------------------------------------------------------
  // compare, bus and closing tasks
  // ---------------------------------------------------------------
  task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic reg_write(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    @(posedge sys_clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // read data is taken only in the cycle after the strobe
  task automatic reg_check(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk16(reg_rdata, exp);
  endtask : reg_check

  task automatic tbl_read(input logic [PA_W-1:0] src, input logic [PA_W-1:0] dst,
                          input logic [TBL_DATA_W-1:0] mem, input logic exp_blk);
    @(posedge sys_clk);
    req.vld      <= 1'b1;
    req.src_addr <= src;
    req.dst_addr <= dst;
    mem_data     <= mem;
    @(posedge sys_clk);
    req.vld      <= 1'b0;
    mem_data     <= ~mem;
    #1;
    chk16({15'h0, rsp.vld}, 16'h0001);
    chk16({15'h0, rsp.blocked}, {15'h0, exp_blk});
    chk16({8'h0, rsp.data}, exp_blk ? 16'h0000 : {8'h0, mem});
    chk16(rsp.dst_addr[15:0], dst[15:0]);
  endtask : tbl_read

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic scen_reset_values;
    reg_check(CP_CFG_ADDR, 16'h0003);
    reg_check(TRG_CFG_ADDR, 16'h020f);
    chk16({15'h0, data_prot}, 16'h0000);
    chk16({15'h0, prog_prot}, 16'h0000);
  endtask : scen_reset_values

  // each strap pattern, then a write that must not stick
  task automatic scen_protect_flags;
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      cp_strap <= 2'(s);
      repeat (5) @(posedge sys_clk);
      #1;
      chk16({15'h0, data_prot}, {15'h0, ~cp_strap[1]});
      chk16({15'h0, prog_prot}, {15'h0, ~cp_strap[0]});
      reg_write(CP_CFG_ADDR, {14'h0, ~cp_strap});
      reg_check(CP_CFG_ADDR, {14'h0, cp_strap});
    end
  endtask : scen_protect_flags

  task automatic scen_id_words;
    reg_write(ID_ADDR, ~TB_PART_ID);
    reg_write(REV_ADDR, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      reg_check(ID_ADDR, TB_PART_ID);
      reg_check(REV_ADDR, {FAMILY_PATTERN, TB_MAJOR, TB_MINOR});
    end
    @(posedge sys_clk);
    #1;
    chk16(reg_rdata, 16'h0000);
    reg_check(22'h0000f0, 16'h0000);
  endtask : scen_id_words

  task automatic scen_guard_register;
    reg_write(TRG_CFG_ADDR, 16'hffff);
    reg_check(TRG_CFG_ADDR, 16'h020f);
    reg_write(TRG_CFG_ADDR, 16'h0000);
    reg_check(TRG_CFG_ADDR, 16'h0000);
    reg_write(TRG_CFG_ADDR, 16'hfdfa);
    reg_check(TRG_CFG_ADDR, 16'h000a);
  endtask : scen_guard_register

  // clear one guard at a time, probe all five regions from outside
  task automatic scen_table_guards;
    logic [PA_W-1:0] dst;
    int              bitpos;
    for (int k = 0; k < 5; k++) begin
      bitpos = (k == 4) ? 9 : k;
      reg_write(TRG_CFG_ADDR, 16'h020f ^ (16'h0001 << bitpos));
      for (int j = 0; j < 5; j++) begin
        dst = (j == 4) ? 17'h00010 : 17'(j * 17'h04000 + 17'h00900);
        tbl_read(FOREIGN, dst, 8'(8'h51 + j), (j == k));
        if (j == k) begin
          tbl_read(dst + 17'h00004, dst, 8'h3c, 1'b0);
        end
      end
    end
    reg_check(BLK_STAT_ADDR, 16'h0001);
    reg_check(BLK_CNT_ADDR, 16'h0005);
    reg_check(BLK_DST_ADDR, 16'h0010);
    reg_write(BLK_STAT_ADDR, 16'h0001);
    reg_write(BLK_CNT_ADDR, 16'h0000);
    reg_check(BLK_STAT_ADDR, 16'h0000);
    reg_check(BLK_CNT_ADDR, 16'h0000);
    reg_write(TRG_CFG_ADDR, 16'h020f);
    tbl_read(FOREIGN, 17'h00010, 8'ha6, 1'b0);
    tbl_read(FOREIGN, 17'h0c200, 8'h6a, 1'b0);
  endtask : scen_table_guards

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    scen_reset_values();
    scen_protect_flags();
    scen_id_words();
    scen_guard_register();
    scen_table_guards();
    report_and_stop();
  end

  // whole run is under two hundred cycles; this leaves wide margin
  initial begin
    #(4 * 20000);
    fails++;
    report_and_stop();
  end

endmodule : tb
